// ### hw/rrm_pkg.sv
// Shared constants, layouts and reset image of the radio register bank
package rrm_pkg;

    // Command byte layout
    localparam int CMD_DIR_BIT = 7;          // 1 = write, 0 = read
    localparam int CMD_INC_BIT = 6;          // 1 = address auto increment

    // Register addresses
    localparam logic [5:0] ADDR_ID           = 6'h00;
    localparam logic [5:0] ADDR_SYN_LOW      = 6'h01;
    localparam logic [5:0] ADDR_SYN_HIGH     = 6'h02;
    localparam logic [5:0] ADDR_RADIO_CTL    = 6'h03;
    localparam logic [5:0] ADDR_RATE_SEL     = 6'h04;
    localparam logic [5:0] ADDR_DEV_CFG      = 6'h05;
    localparam logic [5:0] ADDR_SER_CTL      = 6'h06;
    localparam logic [5:0] ADDR_RX_IRQ_EN    = 6'h07;
    localparam logic [5:0] ADDR_RX_IRQ_STAT  = 6'h08;
    localparam logic [5:0] ADDR_RX_BYTE_A    = 6'h09;
    localparam logic [5:0] ADDR_RX_VALID_A   = 6'h0a;
    localparam logic [5:0] ADDR_RX_BYTE_B    = 6'h0b;
    localparam logic [5:0] ADDR_RX_VALID_B   = 6'h0c;
    localparam logic [5:0] ADDR_TX_IRQ_EN    = 6'h0d;
    localparam logic [5:0] ADDR_TX_IRQ_STAT  = 6'h0e;
    localparam logic [5:0] ADDR_TX_BYTE      = 6'h0f;
    localparam logic [5:0] ADDR_TX_VALID     = 6'h10;
    localparam logic [5:0] ADDR_CODE_LO      = 6'h11;
    localparam logic [5:0] ADDR_CODE_HI      = 6'h18;
    localparam logic [5:0] ADDR_THRESH_LO    = 6'h19;
    localparam logic [5:0] ADDR_THRESH_HI    = 6'h1a;
    localparam logic [5:0] ADDR_WAKE_EN      = 6'h1c;
    localparam logic [5:0] ADDR_WAKE_STAT    = 6'h1d;
    localparam logic [5:0] ADDR_ANALOG_CTL   = 6'h20;
    localparam logic [5:0] ADDR_CHANNEL      = 6'h21;
    localparam logic [5:0] ADDR_SIGNAL       = 6'h22;
    localparam logic [5:0] ADDR_PA_CTL       = 6'h23;
    localparam logic [5:0] ADDR_XTAL_TRIM    = 6'h24;
    localparam logic [5:0] ADDR_OSC_CAL      = 6'h26;
    localparam logic [5:0] ADDR_GAIN_CTL     = 6'h2e;
    localparam logic [5:0] ADDR_CARRIER      = 6'h2f;
    localparam logic [5:0] ADDR_CLK_MANUAL   = 6'h30;
    localparam logic [5:0] ADDR_CLK_GATE     = 6'h31;
    localparam logic [5:0] ADDR_SETTLE_CNT   = 6'h38;
    localparam logic [5:0] ADDR_SERIAL_LO    = 6'h3c;
    localparam logic [5:0] ADDR_SERIAL_HI    = 6'h3f;

    // Field positions
    localparam int CHAN_MODE_BIT = 7;        // 1 = direct divider tuning
    localparam int WAKE_OSC_BIT  = 0;        // Oscillator ready pending

    // Field masks; reserved bits are never stored
    localparam logic [7:0] MASK_FULL     = 8'hff;
    localparam logic [7:0] MASK_SYN_LOW  = 8'h1f;
    localparam logic [7:0] MASK_SYN_HIGH = 8'h7f;
    localparam logic [7:0] MASK_NONE     = 8'h00;

    // Reset values
    localparam logic [63:0] CODE_RESET     = 64'h1e8b6a3de0e9b222;
    localparam logic [7:0]  DEV_CFG_RESET  = 8'h01;
    localparam logic [7:0]  SER_CTL_RESET  = 8'h03;
    localparam logic [7:0]  THR_LO_RESET   = 8'h08;
    localparam logic [7:0]  THR_HI_RESET   = 8'h38;
    localparam logic [7:0]  WAKE_RESET     = 8'h01;
    localparam logic [7:0]  ANALOG_RESET   = 8'h04;
    localparam logic [7:0]  SETTLE_RESET   = 8'h64;
    localparam logic [7:0]  ZERO_RESET     = 8'h00;

    // Divider base count added to the channel number
    localparam logic [11:0] SYN_BASE_COUNT = 12'h940;

    // Radio-side state shown in read-only registers
    typedef struct packed {
        logic [7:0] rx_irq_status;
        logic [7:0] rx_byte_a;
        logic [7:0] rx_valid_a;
        logic [7:0] rx_byte_b;
        logic [7:0] rx_valid_b;
        logic [7:0] tx_irq_status;
        logic [7:0] signal_strength;
    } rrm_status_t;

    // Synthesizer setting handed to the radio
    typedef struct packed {
        logic       direct;
        logic [6:0] high;
        logic [4:0] low;
    } rrm_synth_t;

    // Reset value of a stored register
    function automatic logic [7:0] reg_reset(input int idx);
        logic [5:0] a;
        a = 6'(idx);
        if (a >= ADDR_CODE_LO && a <= ADDR_CODE_HI) begin
            return CODE_RESET[8*(idx-int'(ADDR_CODE_LO)) +: 8];
        end
        case (a)
            ADDR_DEV_CFG:    return DEV_CFG_RESET;
            ADDR_SER_CTL:    return SER_CTL_RESET;
            ADDR_THRESH_LO:  return THR_LO_RESET;
            ADDR_THRESH_HI:  return THR_HI_RESET;
            ADDR_ANALOG_CTL: return ANALOG_RESET;
            ADDR_SETTLE_CNT: return SETTLE_RESET;
            default:         return ZERO_RESET;
        endcase
    endfunction : reg_reset

    // Writable bits of each address; zero for read-only and unmapped
    function automatic logic [7:0] reg_wmask(input int idx);
        logic [5:0] a;
        a = 6'(idx);
        if (a >= ADDR_CODE_LO && a <= ADDR_CODE_HI) begin
            return MASK_FULL;
        end
        case (a)
            ADDR_SYN_LOW:    return MASK_SYN_LOW;
            ADDR_SYN_HIGH:   return MASK_SYN_HIGH;
            ADDR_RADIO_CTL, ADDR_RATE_SEL, ADDR_DEV_CFG, ADDR_SER_CTL,
            ADDR_RX_IRQ_EN, ADDR_TX_IRQ_EN, ADDR_TX_BYTE, ADDR_TX_VALID,
            ADDR_THRESH_LO, ADDR_THRESH_HI, ADDR_WAKE_EN,
            ADDR_ANALOG_CTL, ADDR_CHANNEL, ADDR_PA_CTL, ADDR_XTAL_TRIM,
            ADDR_OSC_CAL, ADDR_GAIN_CTL, ADDR_CARRIER, ADDR_CLK_MANUAL,
            ADDR_CLK_GATE, ADDR_SETTLE_CNT:
                             return MASK_FULL;
            default:         return MASK_NONE;
        endcase
    endfunction : reg_wmask

endpackage : rrm_pkg

// ### hw/rrm_chan_div.sv
// Channel number to synthesizer divider counts
`timescale 1ns/1ps
module rrm_chan_div (
    input  wire logic [6:0] channel,   // Channel number without mode bit
    output logic      [4:0] low,       // Derived low divider count
    output logic      [6:0] high       // Derived high divider count
);

    logic [11:0] total;                // Whole divide ratio

    // Base plus channel, split at 32 into high and low counts
    always_comb begin
        total = rrm_pkg::SYN_BASE_COUNT + {5'h00, channel};
        low   = total[4:0];
        high  = total[11:5];
    end

endmodule : rrm_chan_div

// ### hw/rrm_regs.sv
// Serial-link register bank with synthesizer divider selection
`timescale 1ns/1ps
module rrm_regs #(
    parameter logic [3:0]  SILICON_REV   = 4'h0,         // First revision
    parameter logic [3:0]  PRODUCT_CODE  = 4'h5,         // Arbitrary value
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0000 // Arbitrary value
) (
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic                         sck,
    input  wire logic                         mosi,
    input  wire logic                         ss_n,
    input  wire logic                         osc_ready,
    input  wire rrm_pkg::rrm_status_t         status,
    output logic                              miso,
    output logic                              miso_oe,
    output logic                              wake_pending,
    output rrm_pkg::rrm_synth_t               synth,
    output logic      [63:0]                  spreading_code,
    output logic      [63:0][7:0]             reg_image
);

    // Serial front end state
    logic        sck_q;          // Previous serial clock level
    logic [2:0]  bit_cnt;        // Bits taken in the current byte
    logic [6:0]  in_shift;       // Bits collected so far
    logic [7:0]  out_shift;      // Read byte being sent, msb first
    logic        have_cmd;       // Command byte already taken
    logic        cmd_write;      // Current transfer writes
    logic        cmd_inc;        // Current transfer auto increments
    logic [5:0]  addr;           // Register being addressed

    // Combinational decode
    logic        sck_rise;       // Sampling edge of serial clock
    logic        sck_fall;       // Shift-out edge of serial clock
    logic [7:0]  in_byte;        // Byte completed at this edge
    logic        byte_done;      // Eighth bit sampled
    logic        cmd_phase;      // Command byte completes now
    logic        data_phase;     // Data byte completes now
    logic [5:0]  next_addr;      // Address for the next data byte
    logic        wr_stb;         // Commit a write this cycle
    logic        rd_load;        // Fetch a read byte this cycle
    logic [7:0]  rd_value;       // Read mux result for next_addr

    // Divider path and wake flag
    logic        direct_mode;    // Dividers steer synthesizer
    logic [4:0]  calc_low;       // Low count derived from channel
    logic [6:0]  calc_high;      // High count derived from channel
    logic        wake_flag;      // Pending oscillator ready

    // Serial clock edges; inputs are already in the clock domain
    always_comb begin
        sck_rise = sck & ~sck_q & ~ss_n;
        sck_fall = ~sck & sck_q & ~ss_n;
    end

    // Byte assembly and phase decode
    always_comb begin
        in_byte    = {in_shift, mosi};
        byte_done  = sck_rise & (bit_cnt == 3'h7);
        cmd_phase  = byte_done & ~have_cmd;
        data_phase = byte_done & have_cmd;
    end

    // Address for the following byte of a burst
    always_comb begin
        if (cmd_phase) begin
            next_addr = in_byte[5:0];
        end else if (cmd_inc) begin
            next_addr = addr + 6'h01;
        end else begin
            next_addr = addr;
        end
    end

    // Write commits at the end of each data byte; reads prefetch
    always_comb begin
        wr_stb = data_phase & cmd_write;
        if (cmd_phase) begin
            rd_load = ~in_byte[rrm_pkg::CMD_DIR_BIT];
        end else begin
            rd_load = data_phase & ~cmd_write;
        end
    end

    // Previous serial clock level for edge detection
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
        end
    end

    // Bit counter and input shifter; select high aborts the byte
    always_ff @(posedge clk) begin
        if (srst || ss_n) begin
            bit_cnt  <= 3'h0;
            in_shift <= 7'h00;
        end else if (sck_rise) begin
            bit_cnt  <= bit_cnt + 3'h1;
            in_shift <= in_byte[6:0];
        end
    end

    // Command capture and burst address tracking
    always_ff @(posedge clk) begin
        if (srst || ss_n) begin
            have_cmd  <= 1'b0;
            cmd_write <= 1'b0;
            cmd_inc   <= 1'b0;
            addr      <= 6'h00;
        end else if (byte_done) begin
            // Burst runs until select rises; with increment set, one address per byte
            have_cmd <= 1'b1;
            addr     <= next_addr;
            if (cmd_phase) begin
                cmd_write <= in_byte[rrm_pkg::CMD_DIR_BIT];
                cmd_inc   <= in_byte[rrm_pkg::CMD_INC_BIT];
            end
        end
    end

    // Read byte loads on the last sampling edge, shifts on falls
    always_ff @(posedge clk) begin
        if (srst || ss_n) begin
            out_shift <= 8'h00;
            miso      <= 1'b0;
        end else if (rd_load) begin
            // First falling edge after this puts bit 7 out
            out_shift <= rd_value;
        end else if (sck_fall) begin
            miso      <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
        end
    end

    // Drive the data-out pin only while selected
    always_ff @(posedge clk) begin
        if (srst) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= ~ss_n;
        end
    end

    // Stored registers, one per address; masks drop reserved bits
    for (genvar i = 0; i < 64; i++) begin : g_store
        localparam logic [7:0] RST  = rrm_pkg::reg_reset(i);
        localparam logic [7:0] MASK = rrm_pkg::reg_wmask(i);
        // Address with a zero mask never changes: read-only or hole
        always_ff @(posedge clk) begin
            if (srst) begin
                reg_image[i] <= RST;
            end else if (wr_stb && addr == 6'(i)) begin
                reg_image[i] <= in_byte & MASK;
            end
        end
    end

    // Code register bytes, lowest address least significant
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            spreading_code[8*b +: 8] =
                reg_image[int'(rrm_pkg::ADDR_CODE_LO) + b];
        end
    end

    // Channel number feeds the divider calculation
    rrm_chan_div u_chan_div (
        .channel (reg_image[rrm_pkg::ADDR_CHANNEL][6:0]),
        .low     (calc_low),
        .high    (calc_high)
    );

    // Tuning source follows the channel mode bit
    always_comb begin
        direct_mode =
            reg_image[rrm_pkg::ADDR_CHANNEL][rrm_pkg::CHAN_MODE_BIT];
    end

    // Synthesizer setting registered so the radio sees clean levels
    always_ff @(posedge clk) begin
        if (srst) begin
            synth <= '0;
        end else if (direct_mode) begin
            synth.direct <= 1'b1;
            synth.high   <= reg_image[rrm_pkg::ADDR_SYN_HIGH][6:0];
            synth.low    <= reg_image[rrm_pkg::ADDR_SYN_LOW][4:0];
        end else begin
            synth.direct <= 1'b0;
            synth.high   <= calc_high;
            synth.low    <= calc_low;
        end
    end

    // Wake flag: oscillator event sets, a read fetch clears
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_flag <= rrm_pkg::WAKE_RESET[rrm_pkg::WAKE_OSC_BIT];
        end else if (osc_ready) begin
            // Set wins so an event during the read is kept
            wake_flag <= 1'b1;
        end else if (rd_load && next_addr == rrm_pkg::ADDR_WAKE_STAT) begin
            wake_flag <= 1'b0;
        end
    end

    // Pending wake shown as a pin for polling-free designs
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_pending <= 1'b0;
        end else begin
            wake_pending <= wake_flag;
        end
    end

    // Read mux for the byte about to be sent
    always_comb begin
        unique case (next_addr)
            rrm_pkg::ADDR_ID:
                rd_value = {SILICON_REV, PRODUCT_CODE};
            rrm_pkg::ADDR_SYN_LOW:
                // Channel mode shows derived count, not stored one
                rd_value = direct_mode
                    ? reg_image[rrm_pkg::ADDR_SYN_LOW]
                    : {3'h0, calc_low};
            rrm_pkg::ADDR_SYN_HIGH:
                rd_value = direct_mode
                    ? reg_image[rrm_pkg::ADDR_SYN_HIGH]
                    : {1'b0, calc_high};
            rrm_pkg::ADDR_RX_IRQ_STAT:
                rd_value = status.rx_irq_status;
            rrm_pkg::ADDR_RX_BYTE_A:
                rd_value = status.rx_byte_a;
            rrm_pkg::ADDR_RX_VALID_A:
                rd_value = status.rx_valid_a;
            rrm_pkg::ADDR_RX_BYTE_B:
                rd_value = status.rx_byte_b;
            rrm_pkg::ADDR_RX_VALID_B:
                rd_value = status.rx_valid_b;
            rrm_pkg::ADDR_TX_IRQ_STAT:
                rd_value = status.tx_irq_status;
            rrm_pkg::ADDR_WAKE_STAT:
                rd_value = {7'h00, wake_flag};
            rrm_pkg::ADDR_SIGNAL:
                rd_value = status.signal_strength;
            rrm_pkg::ADDR_SERIAL_LO:
                rd_value = SERIAL_NUMBER[7:0];
            rrm_pkg::ADDR_SERIAL_LO + 6'h01:
                rd_value = SERIAL_NUMBER[15:8];
            rrm_pkg::ADDR_SERIAL_LO + 6'h02:
                rd_value = SERIAL_NUMBER[23:16];
            rrm_pkg::ADDR_SERIAL_HI:
                rd_value = SERIAL_NUMBER[31:24];
            default:
                // Holes hold reset zero and never take writes
                rd_value = reg_image[next_addr];
        endcase
    end

endmodule : rrm_regs

// ### testbench/rrm_regs_properties.sv
// Concurrent checks on the radio register bank ports
`timescale 1ns/1ps
module rrm_regs_checker (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic                ss_n,
    input wire logic                osc_ready,
    input wire logic                miso_oe,
    input wire logic                wake_pending,
    input wire rrm_pkg::rrm_synth_t synth,
    input wire logic [63:0]         spreading_code,
    input wire logic [63:0][7:0]    reg_image
);
    // Single domain; reset masks every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Pin driven only while selected, one cycle late
    property p_oe_select;
        !$past(srst) |-> miso_oe == !$past(ss_n);
    endproperty
    a_oe_select: assert property (p_oe_select)
        else $error("miso enable does not follow select");

    // Code bytes reach the port lowest address in low bits
    property p_code_order;
        spreading_code == {reg_image[24], reg_image[23], reg_image[22],
            reg_image[21], reg_image[20], reg_image[19], reg_image[18],
            reg_image[17]};
    endproperty
    a_code_order: assert property (p_code_order)
        else $error("spreading code byte order wrong");

    // Reserved divider bits never stored
    property p_low_reserved;
        reg_image[1][7:5] == 3'h0 && reg_image[2][7] == 1'b0;
    endproperty
    a_low_reserved: assert property (p_low_reserved)
        else $error("reserved divider bits set");

    // Mode bit of channel picks the tuning source
    property p_mode;
        !$past(srst) |-> synth.direct == $past(reg_image[33][7]);
    endproperty
    a_mode: assert property (p_mode)
        else $error("tuning source does not follow channel bit");

    // Direct mode hands over the stored counts
    property p_direct_counts;
        $past(reg_image[33][7]) && !$past(srst) |->
            {synth.high, synth.low} ==
            {$past(reg_image[2][6:0]), $past(reg_image[1][4:0])};
    endproperty
    a_direct_counts: assert property (p_direct_counts)
        else $error("direct counts not passed on");

    // Channel mode derives counts from base plus channel
    property p_chan_counts;
        !$past(reg_image[33][7]) && !$past(srst) |->
            {synth.high, synth.low} ==
            rrm_pkg::SYN_BASE_COUNT + {5'h00, $past(reg_image[33][6:0])};
    endproperty
    a_chan_counts: assert property (p_chan_counts)
        else $error("derived counts wrong");

    // Oscillator ready shows on the flag two edges on
    property p_wake_set;
        osc_ready |-> ##2 wake_pending;
    endproperty
    a_wake_set: assert property (p_wake_set)
        else $error("wake flag not raised");

    // Defaults present right after reset
    property p_reset_defaults;
        $past(srst) |-> reg_image[5] == rrm_pkg::DEV_CFG_RESET &&
            reg_image[6] == rrm_pkg::SER_CTL_RESET &&
            reg_image[56] == rrm_pkg::SETTLE_RESET;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("register defaults missing after reset");

    // No write lands in the channel register while the device is deselected
    property p_idle_stable;
        ss_n && $past(ss_n) && !$past(srst) |-> $stable(reg_image[33]);
    endproperty
    a_idle_stable: assert property (p_idle_stable)
        else $error("channel changed while deselected");
endmodule : rrm_regs_checker

bind rrm_regs rrm_regs_checker i_chk (.clk(clk), .srst(srst),
    .ss_n(ss_n), .osc_ready(osc_ready), .miso_oe(miso_oe),
    .wake_pending(wake_pending), .synth(synth),
    .spreading_code(spreading_code), .reg_image(reg_image));

// ### testbench/rrm_host.sv
// Serial link master model standing in for the host controller
`timescale 1ns/1ps
module rrm_host (
    input  wire logic clk,
    input  wire logic miso,
    input  wire logic miso_oe,
    output logic      sck,
    output logic      mosi,
    output logic      ss_n
);
    localparam int HALF = 3;  // Serial half period; design needs >= 1

    // Idle: clock parked low, deselected
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end

    // Let n edges pass, then settle just after the last
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Whole frame: command then n data bytes, low byte first
    task automatic access(input logic [7:0] cmd, input int n,
                          input logic [63:0] wd, output logic [63:0] rd);
        logic [7:0] b;
        logic [7:0] r;
        rd = 64'h0;
        tick(1);
        ss_n = 1'b0;
        for (int k = 0; k <= n; k++) begin
            b = (k == 0) ? cmd : wd[8*(k-1) +: 8];
            for (int i = 7; i >= 0; i--) begin
                tick(HALF);
                sck = 1'b0;
                mosi = b[i];
                tick(HALF);
                r[i] = miso_oe ? miso : 1'bx;  // Undriven pin never matches
                sck = 1'b1;
            end
            if (k > 0) begin
                rd[8*(k-1) +: 8] = r;
            end
        end
        tick(HALF);
        sck = 1'b0;
        tick(HALF);
        ss_n = 1'b1;
        mosi = ~mosi;  // Released line shows no stale value
    endtask : access
endmodule : rrm_host

// ### testbench/radio_register_map_synth_divider_bench.sv
// Self-checking bench for the radio register bank
`timescale 1ns/1ps
module radio_register_map_synth_divider_bench;
    logic                clk;
    logic                srst;
    logic                osc_ready;
    rrm_pkg::rrm_status_t status;
    logic                sck;
    logic                mosi;
    logic                ss_n;
    logic                miso;
    logic                miso_oe;
    logic                wake_pending;
    rrm_pkg::rrm_synth_t synth;
    logic [63:0]         spreading_code;
    logic [63:0][7:0]    reg_image;
    int                  miscompares = 0;
    int                  checked = 0;
    localparam logic [55:0] STAT = 56'h11_22_33_44_55_66_a7;
    localparam logic [31:0] SERIAL = 32'h4433_2211;  // Arbitrary value

    rrm_regs #(.SERIAL_NUMBER(SERIAL)) i_dut (.clk(clk), .srst(srst),
        .sck(sck), .mosi(mosi), .ss_n(ss_n), .osc_ready(osc_ready),
        .status(status), .miso(miso), .miso_oe(miso_oe),
        .wake_pending(wake_pending), .synth(synth),
        .spreading_code(spreading_code), .reg_image(reg_image));
    rrm_host i_host (.clk(clk), .miso(miso), .miso_oe(miso_oe),
        .sck(sck), .mosi(mosi), .ss_n(ss_n));

    // 4 ns clock
    always #2 clk = ~clk;

    // Compare and count
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Burst write with increment
    task automatic wr(input logic [5:0] a, input int n, input logic [63:0] d);
        logic [63:0] unused;
        i_host.access({2'b11, a}, n, d, unused);
    endtask : wr

    // Burst read with increment
    task automatic rd(input logic [5:0] a, input int n, output logic [63:0] v);
        i_host.access({2'b01, a}, n, 64'h0, v);
    endtask : rd

    // Reset image, little-endian code, read-clear of wake
    task automatic t_defaults;
        logic [63:0] v;
        rd(rrm_pkg::ADDR_ID, 1, v);
        check("id", v, 64'h05);
        rd(rrm_pkg::ADDR_CODE_LO, 8, v);
        check("code", v, rrm_pkg::CODE_RESET);
        rd(rrm_pkg::ADDR_DEV_CFG, 2, v);
        check("cfg", v, 64'h0301);
        rd(rrm_pkg::ADDR_SETTLE_CNT, 1, v);
        check("settle", v, 64'h64);
        rd(rrm_pkg::ADDR_WAKE_STAT, 1, v);
        check("wake first", v, 64'h01);
        rd(rrm_pkg::ADDR_WAKE_STAT, 1, v);
        check("wake again", v, 64'h00);
        $display("test defaults done");
    endtask : t_defaults

    // Channel tuning, then direct low count at both ends of its range
    task automatic t_tuning;
        logic [63:0] v;
        wr(rrm_pkg::ADDR_CHANNEL, 1, 64'h05);
        rd(rrm_pkg::ADDR_SYN_LOW, 2, v);
        check("derived", v, 64'h4a05);
        check("synth chan", 64'(synth), 64'h0945);
        wr(rrm_pkg::ADDR_SYN_LOW, 2, 64'h4c1f);
        wr(rrm_pkg::ADDR_CHANNEL, 1, 64'h85);
        check("synth top", 64'(synth), 64'h199f);
        rd(rrm_pkg::ADDR_SYN_LOW, 2, v);
        check("counts back", v, 64'h4c1f);
        wr(rrm_pkg::ADDR_SYN_LOW, 2, 64'h4a00);
        check("synth bottom", 64'(synth), 64'h1940);
        i_host.access({2'b10, rrm_pkg::ADDR_PA_CTL}, 2, 64'h2211, v);
        rd(rrm_pkg::ADDR_PA_CTL, 2, v);
        check("no increment", v, 64'h0022);
        i_host.access({2'b00, rrm_pkg::ADDR_PA_CTL}, 2, 64'h0, v);
        check("same address read", v, 64'h2222);
        $display("test tuning done");
    endtask : t_tuning

    // Read-only and unmapped places keep their contents
    task automatic t_protect;
        logic [63:0] v;
        wr(rrm_pkg::ADDR_ID, 1, 64'hff);
        wr(rrm_pkg::ADDR_SIGNAL, 1, 64'hff);
        wr(rrm_pkg::ADDR_SERIAL_LO, 4, 64'hffff_ffff);
        wr(6'h3a, 1, 64'hff);
        rd(rrm_pkg::ADDR_ID, 1, v);
        check("id kept", v, 64'h05);
        rd(rrm_pkg::ADDR_RX_IRQ_STAT, 1, v);
        check("rx status", v, 64'h11);
        rd(rrm_pkg::ADDR_SIGNAL, 1, v);
        check("strength", v, 64'ha7);
        rd(rrm_pkg::ADDR_SERIAL_LO, 4, v);
        check("serial", v, 64'(SERIAL));
        rd(6'h3a, 1, v);
        check("unmapped", v, 64'h00);
        $display("test protect done");
    endtask : t_protect

    // Oscillator ready sets the flag, a read clears it
    task automatic t_wake;
        logic [63:0] v;
        @(posedge clk);
        #1 osc_ready = 1'b1;
        @(posedge clk);
        #1 osc_ready = 1'b0;
        repeat (2) @(posedge clk);
        #1 check("wake pin", 64'(wake_pending), 64'h1);
        rd(rrm_pkg::ADDR_WAKE_STAT, 1, v);
        check("wake set", v, 64'h01);
        rd(rrm_pkg::ADDR_WAKE_STAT, 1, v);
        check("wake clear", v, 64'h00);
        check("wake pin low", 64'(wake_pending), 64'h0);
        $display("test wake done");
    endtask : t_wake

    // Reset in mid-run restores the channel default
    task automatic t_rereset;
        logic [63:0] v;
        @(posedge clk);
        #1 srst = 1'b1;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        rd(rrm_pkg::ADDR_CHANNEL, 1, v);
        check("channel reset", v, 64'h00);
        check("synth reset", 64'(synth), 64'h0940);
        rd(rrm_pkg::ADDR_WAKE_STAT, 1, v);
        check("wake after reset", v, 64'h01);
        $display("test rereset done");
    endtask : t_rereset

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        osc_ready = 1'b0;
        status = STAT;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        t_defaults();
        t_tuning();
        t_protect();
        t_wake();
        t_rereset();
        tally_and_finish();
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("BAD watchdog expected finish seen hang");
        tally_and_finish();
    end
endmodule : radio_register_map_synth_divider_bench
